//--- pacs_clock_select.sv
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module pacs_clock_select (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [2:0] cfg_source_sel_i,
  input wire logic [1:0] cfg_primary_mode_i,
  input wire logic cfg_out_pin_func_i,
  input wire logic osc_in_pin_i,
  input wire logic osc_out_pin_i,
  input wire logic sec_osc_i,
  input wire logic aux_osc_i,
  input wire logic frc_clk_i,
  input wire logic frc_pll_clk_i,
  input wire logic pll_clk_i,
  input wire logic brownout_i,
  input wire logic sleep_i,
  input wire logic sec_osc_en_i,
  input wire logic [1:0] gpio_out_i,
  input wire logic [1:0] gpio_oe_i,
  output logic osc_in_o,
  output logic osc_in_oe_o,
  output logic osc_out_o,
  output logic osc_out_oe_o,
  output logic pri_osc_en_o,
  output logic [1:0] pri_osc_mode_o,
  output logic aux_osc_en_o,
  output logic [1:0] aux_osc_mode_o,
  output logic sys_clk_o,
  output logic clk_ready_o,
  output logic sec_ready_o,
  output logic aux_clk_o
);
  import pacs_pkg::*;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ****************************************
  // Input synchronisers.
  // ****************************************
  logic [8:0] raw_in;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] sync3;
  logic [8:0] rise;
  logic [8:0] flip;

  assign raw_in = {osc_in_pin_i, osc_out_pin_i, sec_osc_i, aux_osc_i,
                   frc_clk_i, frc_pll_clk_i, pll_clk_i, brownout_i, sleep_i};

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise = sync2 & ~sync3;
  assign flip = sync2 ^ sync3;

  // ****************************************
  // Stored configuration.
  // ****************************************
  logic cfg_loaded;
  logic [2:0] src_cfg;
  logic [1:0] mode_cfg;
  logic fnc_cfg;
  logic next_cfg_loaded;
  logic [2:0] next_src_cfg;
  logic [1:0] next_mode_cfg;
  logic next_fnc_cfg;

  always_comb begin
    next_cfg_loaded = 1'b1;
    next_src_cfg = src_cfg;
    next_mode_cfg = mode_cfg;
    next_fnc_cfg = fnc_cfg;
    if (!cfg_loaded) begin
      next_src_cfg = cfg_source_sel_i;
      next_mode_cfg = cfg_primary_mode_i;
      next_fnc_cfg = cfg_out_pin_func_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_loaded <= 1'b0;
      src_cfg <= '0;
      mode_cfg <= '0;
      fnc_cfg <= 1'b0;
    end else begin
      cfg_loaded <= next_cfg_loaded;
      src_cfg <= next_src_cfg;
      mode_cfg <= next_mode_cfg;
      fnc_cfg <= next_fnc_cfg;
    end
  end

  assign pri_osc_mode_o = mode_cfg;

  a_cfg_capture: assert property (
    $rose(cfg_loaded) |-> src_cfg == $past(cfg_source_sel_i))
    else $error("Source not taken from configuration.");
  a_cfg_frozen: assert property (
    cfg_loaded |=> $stable(src_cfg) && $stable(mode_cfg) && $stable(fnc_cfg))
    else $error("Stored configuration changed at run time.");

  // ****************************************
  // Start-up timers and ready sequencing.
  // ****************************************
  logic restart;
  logic pri_en;
  logic pri_done;
  logic uses_pri;
  pacs_state_e state;
  pacs_state_e next_state;
  logic [7:0] lock_cnt;
  logic [7:0] next_lock_cnt;
  logic next_ready;

  assign restart = !cfg_loaded || sync2[1] || sync2[0];
  assign pri_en = cfg_loaded && (mode_cfg != PMODE_OFF);
  assign uses_pri = (src_cfg == SRC_PRI) || (src_cfg == SRC_PRI_PLL);

  pacs_startup_timer u_pri_timer (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(restart || !pri_en),
    .osc_rise_i(rise[8]),
    .done_o(pri_done)
  );

  pacs_startup_timer u_sec_timer (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(restart || !sec_osc_en_i),
    .osc_rise_i(rise[6]),
    .done_o(sec_ready_o)
  );

  always_comb begin
    next_state = state;
    next_lock_cnt = '0;
    case (state)
      ST_WAIT_OSC: begin
        if (!uses_pri) begin
          next_state = ST_READY;
        end else if (pri_done) begin
          next_state = (src_cfg == SRC_PRI_PLL) ? ST_WAIT_LOCK : ST_READY;
        end
      end
      ST_WAIT_LOCK: begin
        next_lock_cnt = 8'(lock_cnt + 8'h01);
        if (lock_cnt == LOCK_LAST) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        next_state = ST_READY;
      end
      default: begin
        next_state = ST_WAIT_OSC;
      end
    endcase
    if (restart) begin
      next_state = ST_WAIT_OSC;
      next_lock_cnt = '0;
    end
    next_ready = (next_state == ST_READY);
  end

  // ****************************************
  // System clock selection.
  // ****************************************
  logic sel_lvl;
  logic fcy;
  logic next_sys;
  logic next_fcy;

  always_comb begin
    case (src_cfg)
      SRC_PRI: sel_lvl = sync2[8];
      SRC_PRI_PLL: sel_lvl = sync2[2];
      SRC_FRC_PLL: sel_lvl = sync2[3];
      default: sel_lvl = sync2[4];
    endcase
    next_sys = clk_ready_o && sel_lvl;
    next_fcy = fcy;
    if (!clk_ready_o) begin
      next_fcy = 1'b0;
    end else if (next_sys && !sys_clk_o) begin
      next_fcy = ~fcy;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_WAIT_OSC;
      lock_cnt <= '0;
      clk_ready_o <= 1'b0;
      sys_clk_o <= 1'b0;
      fcy <= 1'b0;
    end else begin
      state <= next_state;
      lock_cnt <= next_lock_cnt;
      clk_ready_o <= next_ready;
      sys_clk_o <= next_sys;
      fcy <= next_fcy;
    end
  end

  sequence s_lock_end;
    state == ST_WAIT_LOCK && lock_cnt == LOCK_LAST && !restart;
  endsequence

  a_ready_timer: assert property (
    clk_ready_o && uses_pri |-> pri_done)
    else $error("Clock ready before the start-up timer ended.");
  a_pll_lock_wait: assert property (
    $rose(clk_ready_o) && src_cfg == SRC_PRI_PLL |->
      $past(state == ST_WAIT_LOCK && lock_cnt == LOCK_LAST))
    else $error("PLL path ready without the lock delay.");
  a_lock_release: assert property (
    s_lock_end |=> clk_ready_o)
    else $error("Clock not ready after the lock delay.");
  a_restart_drop: assert property (
    restart |=> !clk_ready_o && state == ST_WAIT_OSC)
    else $error("Restart did not drop clock ready.");

  // ****************************************
  // Oscillator pins.
  // ****************************************
  logic pin_mode_gpio;
  logic next_in_o;
  logic next_in_oe;
  logic next_out_o;
  logic next_out_oe;

  assign pin_mode_gpio = (mode_cfg == PMODE_EXT) || (mode_cfg == PMODE_OFF);

  always_comb begin
    next_in_o = 1'b0;
    next_in_oe = 1'b0;
    next_out_o = 1'b0;
    next_out_oe = 1'b0;
    if (cfg_loaded && mode_cfg == PMODE_OFF) begin
      next_in_o = gpio_out_i[0];
      next_in_oe = gpio_oe_i[0];
    end
    if (cfg_loaded && pin_mode_gpio) begin
      if (fnc_cfg) begin
        next_out_o = fcy;
        next_out_oe = 1'b1;
      end else begin
        next_out_o = gpio_out_i[1];
        next_out_oe = gpio_oe_i[1];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_in_o <= 1'b0;
      osc_in_oe_o <= 1'b0;
      osc_out_o <= 1'b0;
      osc_out_oe_o <= 1'b0;
      pri_osc_en_o <= 1'b0;
    end else begin
      osc_in_o <= next_in_o;
      osc_in_oe_o <= next_in_oe;
      osc_out_o <= next_out_o;
      osc_out_oe_o <= next_out_oe;
      pri_osc_en_o <= pri_en;
    end
  end

  a_in_pin_osc: assert property (
    mode_cfg != PMODE_OFF |=> !osc_in_oe_o)
    else $error("Input pin driven while serving the oscillator.");
  a_out_pin_owned: assert property (
    !pin_mode_gpio |=> !osc_out_oe_o)
    else $error("Output pin driven in crystal or high-speed mode.");
  a_out_pin_clock: assert property (
    cfg_loaded && pin_mode_gpio && fnc_cfg |=>
      osc_out_oe_o && osc_out_o == $past(fcy))
    else $error("Output pin does not carry the cycle clock.");

  // ****************************************
  // Auxiliary clock register and path.
  // ****************************************
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic [1:0] act;
  logic [1:0] want;
  logic [1:0] next_act;
  logic div_clr;
  logic aux_flip;
  logic ref_flip;
  logic div_edge;
  logic next_aux_en;
  logic wr_acc;

  assign want = {acc[SEL_SRC_BIT], acc[REF_SEL_BIT]};
  assign div_clr = (want != act) && !aux_clk_o;
  assign next_act = div_clr ? want : act;
  assign next_aux_en = acc[AMODE_LSB+:2] != AMODE_OFF;
  assign aux_flip = aux_osc_en_o && flip[5];
  assign ref_flip = act[0] ? (flip[8] && pri_done) : aux_flip;
  assign div_edge = act[1] ? ref_flip : flip[3];
  assign aux_osc_mode_o = acc[AMODE_LSB+:2];

  pacs_aux_divider u_aux_div (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .edge_i(div_edge),
    .clr_i(div_clr),
    .code_i(acc[ADIV_LSB+:3]),
    .clk_o(aux_clk_o)
  );

  // ****************************************
  // Register bus slave.
  // ****************************************
  logic setup;
  logic addr_hit;
  logic [31:0] rd_word;
  logic [31:0] next_prdata;

  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pready_o && pwrite_i &&
                  (paddr_i == ACC_OFFSET);

  always_comb begin
    addr_hit = 1'b1;
    case (paddr_i)
      ACC_OFFSET: rd_word = {16'h0000, acc};
      STATUS_OFFSET: rd_word = {25'h0000000, sync3[7], sync3[8], act,
                                sec_ready_o, pri_done, clk_ready_o};
      CONFIG_OFFSET: rd_word = {25'h0000000, cfg_loaded, fnc_cfg,
                                mode_cfg, src_cfg};
      default: begin
        rd_word = 32'h00000000;
        addr_hit = 1'b0;
      end
    endcase
    next_prdata = (setup && !pwrite_i) ? rd_word : 32'h00000000;
    next_acc = acc;
    if (wr_acc && pstrb_i[1]) begin
      next_acc[15:8] = pwdata_i[15:8];
    end
    if (wr_acc && pstrb_i[0]) begin
      next_acc[7:0] = pwdata_i[7:0];
    end
    next_acc = next_acc & ACC_WMASK;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc <= ACC_RESET;
      act <= '0;
      aux_osc_en_o <= 1'b0;
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      acc <= next_acc;
      act <= next_act;
      aux_osc_en_o <= next_aux_en;
      prdata_o <= next_prdata;
      pready_o <= setup;
      pslverr_o <= setup && !addr_hit;
    end
  end

  a_acc_reserved: assert property (
    psel_i && penable_i && pready_o && !pwrite_i && paddr_i == ACC_OFFSET
      |-> prdata_o[31:14] == '0 && prdata_o[6:0] == '0)
    else $error("Reserved control bits read non-zero.");
  a_aux_mode_en: assert property (
    ##1 aux_osc_en_o == ($past(acc[AMODE_LSB+:2]) != AMODE_OFF))
    else $error("Aux oscillator enable does not follow its mode.");
  a_src_switch_low: assert property (
    act != $past(act) |-> $past(!aux_clk_o) && !aux_clk_o)
    else $error("Aux source switched while the output was high.");
endmodule

//--- pacs_pkg.sv
package pacs_pkg;

  // ****************************************
  // Register map.
  // ****************************************
  localparam logic [11:0] ACC_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] CONFIG_OFFSET = 12'h008;
  localparam int SEL_SRC_BIT = 13;
  localparam int AMODE_LSB = 11;
  localparam int ADIV_LSB = 8;
  localparam int REF_SEL_BIT = 7;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  localparam logic [15:0] ACC_WMASK = 16'h3F80;

  // ****************************************
  // Source and mode codes.
  // ****************************************
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [1:0] PMODE_EXT = 2'h0;
  localparam logic [1:0] PMODE_OFF = 2'h3;
  localparam logic [1:0] AMODE_OFF = 2'h0;
  localparam logic [2:0] DIV_CODE_256 = 3'h0;
  localparam logic [7:0] DIV_MAX = 8'hFF;

  // ****************************************
  // Timing.
  // ****************************************
  localparam int STARTUP_W = 10;
  localparam int STARTUP_CYCLES = 1024;
  localparam logic [9:0] STARTUP_LAST = 10'(STARTUP_CYCLES - 1);
  localparam int CLK_PERIOD_PS = 8000;
  localparam int PLL_LOCK_NS = 2000;
  localparam int PLL_LOCK_CYC =
    (PLL_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] LOCK_LAST = 8'(PLL_LOCK_CYC - 1);

  typedef enum logic [2:0] {
    ST_WAIT_OSC = 3'b001,
    ST_WAIT_LOCK = 3'b010,
    ST_READY = 3'b100
  } pacs_state_e;

endpackage

//--- pacs_startup_timer.sv
`timescale 1ns/10ps
module pacs_startup_timer (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic restart_i,
  input wire logic osc_rise_i,
  output logic done_o
);
  import pacs_pkg::*;

  logic [STARTUP_W-1:0] cnt;
  logic [STARTUP_W-1:0] next_cnt;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_done = done_o;
    if (restart_i) begin
      next_cnt = '0;
      next_done = 1'b0;
    end else if (osc_rise_i && !done_o) begin
      next_cnt = 10'(cnt + 10'h001);
      if (cnt == STARTUP_LAST) begin
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
      done_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done_o <= next_done;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_timer_hold: assert property (
    !restart_i && !osc_rise_i |=> $stable(cnt) && $stable(done_o))
    else $error("Start-up timer moved without an oscillator edge.");
  a_timer_full: assert property (
    $rose(done_o) |-> $past(cnt) == STARTUP_LAST && $past(osc_rise_i))
    else $error("Start-up timer released before the full count.");
  a_timer_restart: assert property (
    restart_i |=> !done_o && cnt == '0)
    else $error("Start-up timer did not restart.");
endmodule

//--- pacs_aux_divider.sv
`timescale 1ns/10ps
module pacs_aux_divider (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic edge_i,
  input wire logic clr_i,
  input wire logic [2:0] code_i,
  output logic clk_o
);
  import pacs_pkg::*;

  logic [7:0] cnt;
  logic [7:0] limit;
  logic [7:0] next_cnt;
  logic [7:0] next_limit;
  logic [7:0] new_limit;
  logic [3:0] shift;
  logic next_clk;

  // Each output phase lasts the divide factor in source transitions.
  assign shift = (code_i == DIV_CODE_256) ? 4'h0 : 4'({1'b0, code_i} + 4'h1);
  assign new_limit = DIV_MAX >> shift;

  always_comb begin
    next_cnt = cnt;
    next_limit = limit;
    next_clk = clk_o;
    if (clr_i) begin
      next_cnt = '0;
      next_clk = 1'b0;
      next_limit = new_limit;
    end else if (edge_i) begin
      if (cnt >= limit) begin
        next_cnt = '0;
        next_clk = ~clk_o;
        next_limit = new_limit;
      end else begin
        next_cnt = 8'(cnt + 8'h01);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
      limit <= DIV_MAX;
      clk_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      limit <= next_limit;
      clk_o <= next_clk;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_div_phase: assert property (
    !clr_i && !(edge_i && cnt >= limit) |=> $stable(clk_o))
    else $error("Divider output changed inside a phase.");
  a_div_limit_hold: assert property (
    !clr_i && !(edge_i && cnt >= limit) |=> $stable(limit))
    else $error("Divide factor changed inside a phase.");
endmodule

//--- pacs_osc_model.sv
`timescale 1ns/10ps
module pacs_osc_model #(
  parameter int HALF_NS = 20
) (
  input wire logic en_i,
  output logic osc_o
);
  // ****************************************
  // Oscillator waveform.
  // ****************************************
  // The pin stays low until the source is enabled, so no edge is seen
  // before a valid swing exists.
  initial begin
    osc_o = 1'b0;
    forever begin
      wait (en_i === 1'b1);
      #(HALF_NS) osc_o = 1'b1;
      #(HALF_NS) osc_o = 1'b0;
    end
  end
endmodule

//--- test_primary_aux_clock_select.sv
`timescale 1ns/10ps
module test_primary_aux_clock_select;
  import pacs_pkg::*;
  logic ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o;
  logic pslverr_o, cfg_out_pin_func_i, osc_in_pin_i, sec_osc_i, aux_osc_i;
  logic frc_clk_i, brownout_i, sleep_i, sec_osc_en_i, osc_in_o, osc_in_oe_o;
  logic osc_out_o, osc_out_oe_o, pri_osc_en_o, aux_osc_en_o, sys_clk_o;
  logic clk_ready_o, sec_ready_o, aux_clk_o, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0] pstrb_i;
  logic [2:0] cfg_source_sel_i;
  logic [1:0] cfg_primary_mode_i, pri_osc_mode_o, aux_osc_mode_o;
  wire frc_pll_clk_i, pll_clk_i, osc_out_pin_i;
  logic [1:0] gpio_out_i, gpio_oe_i;
  int sys_rises = 0;
  int fail_count = 0;
  int comparisons = 0;
  int pri_rises = 0;
  int aux_in_rises = 0;
  int aux_rises = 0;
  int out_rises = 0;
  logic [31:0] row_w [6] = '{32'hFFFF_FFFF, 32'h3800, 32'h1000, 32'h0880,
    32'h0500, 32'h0};
  logic [15:0] row_r [6] = '{16'h3F80, 16'h3800, 16'h1000, 16'h0880,
    16'h0500, 16'h0000};

  assign frc_pll_clk_i = frc_clk_i;
  assign pll_clk_i = frc_clk_i;
  assign osc_out_pin_i = osc_out_o;

  pacs_clock_select i_dut (
    .ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .cfg_source_sel_i,
    .cfg_primary_mode_i, .cfg_out_pin_func_i, .osc_in_pin_i,
    .osc_out_pin_i, .sec_osc_i, .aux_osc_i, .frc_clk_i, .frc_pll_clk_i,
    .pll_clk_i, .brownout_i, .sleep_i, .sec_osc_en_i,
    .gpio_out_i, .gpio_oe_i, .osc_in_o, .osc_in_oe_o,
    .osc_out_o, .osc_out_oe_o, .pri_osc_en_o, .pri_osc_mode_o, .aux_osc_en_o,
    .aux_osc_mode_o, .sys_clk_o, .clk_ready_o, .sec_ready_o, .aux_clk_o
  );

  pacs_osc_model i_pri (.en_i(pri_osc_en_o), .osc_o(osc_in_pin_i));
  pacs_osc_model #(.HALF_NS(28)) i_sec (.en_i(sec_osc_en_i),
    .osc_o(sec_osc_i));
  pacs_osc_model #(.HALF_NS(24)) i_aux (.en_i(aux_osc_en_o),
    .osc_o(aux_osc_i));
  pacs_osc_model #(.HALF_NS(36)) i_frc (.en_i(1'b1), .osc_o(frc_clk_i));

  always @(posedge osc_in_pin_i) pri_rises++;
  always @(posedge aux_osc_i) aux_in_rises++;
  always @(posedge aux_clk_o) aux_rises++;
  always @(posedge osc_out_o) out_rises++;
  always @(posedge sys_clk_o) sys_rises++;

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************
  // Shared tasks.
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n = 0;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    if (n >= 20) fail_count++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic boot(input logic [2:0] s, input logic [1:0] m,
                      input logic f);
    @(posedge ref_clk_i);
    cfg_source_sel_i <= s;
    cfg_primary_mode_i <= m;
    cfg_out_pin_func_i <= f;
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic expect_ready(input int lo, input int hi);
    int base;
    base = pri_rises;
    wait (pri_rises == base + 1020);
    check(clk_ready_o, 0);
    wait (pri_rises == base + 1024);
    repeat (lo) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    if (lo > 0) check(clk_ready_o, 0);
    repeat (hi - lo) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(clk_ready_o, 1);
  endtask

  task automatic aux_div(input logic [2:0] code, input int n);
    int a, r;
    apb(1'b1, ACC_OFFSET, {18'h0, 3'b111, code, 8'h00});
    a = aux_in_rises;
    wait (aux_in_rises == a + 8);
    a = aux_in_rises;
    r = aux_rises;
    wait (aux_in_rises == a + 64);
    check(32'(aux_rises - r >= n - 1 && aux_rises - r <= n + 1), 1);
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #600000;
    fail_count++;
    wrap_up;
  end

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    sys_rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, brownout_i, sleep_i} = 5'h00;
    sec_osc_en_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'hF;
    gpio_out_i = 2'b01;
    gpio_oe_i = 2'b11;
    cfg_source_sel_i = 3'h0;
    cfg_primary_mode_i = 2'h0;
    cfg_out_pin_func_i = 1'b0;
    boot(3'h2, 2'h3, 1'b0);
    check(pri_osc_en_o, 0);
    check(osc_in_oe_o, 1);
    check(osc_in_o, 1);
    check(osc_out_oe_o, 1);
    check(osc_out_o, 0);
    check(pri_osc_mode_o, 3);
    apb(1'b0, CONFIG_OFFSET, 32'h0);
    check(rd, 32'h5A);
    apb(1'b1, CONFIG_OFFSET, 32'h0);
    apb(1'b0, CONFIG_OFFSET, 32'h0);
    check(rd, 32'h5A);
    apb(1'b0, ACC_OFFSET, 32'h0);
    check(rd, 32'h0);
    check(aux_osc_en_o, 0);
    repeat (300) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(clk_ready_o, 0);
    boot(3'h2, 2'h1, 1'b1);
    check(pri_osc_en_o, 1);
    check(osc_in_oe_o, 0);
    check(osc_out_oe_o, 0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ACC_OFFSET, row_w[i]);
      apb(1'b0, ACC_OFFSET, 32'h0);
      check(rd, {16'h0, row_r[i]});
      check(aux_osc_mode_o, row_r[i][12:11]);
      check(aux_osc_en_o, |row_r[i][12:11]);
    end
    apb(1'b0, 12'h00C, 32'h0);
    check(err, 1);
    check(rd, 32'h0);
    aux_div(3'b111, 64);
    aux_div(3'b101, 16);
    aux_div(3'b011, 4);
    @(posedge ref_clk_i);
    sec_osc_en_i <= 1'b1;
    boot(3'h2, 2'h0, 1'b1);
    check(osc_out_oe_o, 1);
    expect_ready(0, 14);
    check(sec_ready_o, 0);
    repeat (3000) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(sec_ready_o, 1);
    check(32'(out_rises > 0), 1);
    check(32'(sys_rises > 0), 1);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk_i);
      if (i == 0) brownout_i <= 1'b1;
      else sleep_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check(clk_ready_o, 0);
      @(posedge ref_clk_i);
      brownout_i <= 1'b0;
      sleep_i <= 1'b0;
      expect_ready(0, 14);
    end
    boot(3'h3, 2'h0, 1'b0);
    expect_ready(230, 275);
    wrap_up;
  end
endmodule
